// ### src/mtx_fifo.sv
/*
  nibble fifo with registered output stage, valid/ready on both sides.
  assumes one clock; out_ready may stall, which fills the fifo and drops in_ready.
*/
`timescale 1ns/1ps
module mtx_fifo import mtx_pkg::*; #(
  parameter int W = TXD_W,
  parameter int D = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic [W-1:0] out_data_ff;
  logic out_valid_ff;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = wr_ptr_ff == rd_ptr_ff;
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign push = in_valid && !full;
  assign pop = !empty && (!out_valid_ff || out_ready);
  assign in_ready = !full;
  assign out_data = out_data_ff;
  assign out_valid = out_valid_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end

  // output register keeps the drain side straight off a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_data_ff <= '0;
      out_valid_ff <= 1'h0;
    end else if (pop) begin
      out_data_ff <= mem[rd_ptr_ff[AW-1:0]];
      out_valid_ff <= 1'h1;
    end else if (out_ready) begin
      out_valid_ff <= 1'h0;
    end
  end

  fifo_full_c: cover property (@(posedge clk) disable iff (!nrst) full);

endmodule

// ### src/mtx_pkg.sv
/*
  constants, state type and timing figures for the 10 Mbps mii transmit status block.
  assumes a single 200 MHz core clock; every link-side time is counted in its cycles.
*/
// Summary of operation
// - the block drives the transmit clock with a 400 ns period, 200 ns high and 200 ns low.
// - about 2.2 us after transmit enable drops, the collision output rises as the sqe test.
// - the sqe collision pulse lasts 1.0 us and is then released.
// - carrier sense rises about 600 ns after transmit enable rises.
// - carrier sense falls about 1.0 us after transmit enable falls.
// - in led_function_select 00 with speed_100 high the speed led goes from low to high about 4.4 us after link loss.
// - in led_function_select 01 the link led goes from low to high in the same link-loss reaction time.
// - the interrupt output rises on a link-down change within that same reaction time.
package mtx_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 5;

  // link-side times, figures as printed
  localparam int TXC_PERIOD_NS = 400;
  localparam int TXC_HALF_NS = 200;
  localparam int CRS_ON_NS = 600;
  localparam real CRS_OFF_US = 1.0;
  localparam real SQE_DELAY_US = 2.2;
  localparam real SQE_PULSE_US = 1.0;
  localparam real LINK_LOSS_US = 4.4;

  // derived cycle counts
  localparam int TXC_HALF_CYC = TXC_HALF_NS / CLK_PERIOD_NS;
  localparam int CRS_ON_CYC = CRS_ON_NS / CLK_PERIOD_NS;
  localparam int CRS_OFF_CYC = int'(CRS_OFF_US * 1000.0 / real'(CLK_PERIOD_NS));
  localparam int SQE_DELAY_CYC = int'(SQE_DELAY_US * 1000.0 / real'(CLK_PERIOD_NS));
  localparam int SQE_PULSE_CYC = int'(SQE_PULSE_US * 1000.0 / real'(CLK_PERIOD_NS));
  localparam int LINK_LOSS_CYC = int'(LINK_LOSS_US * 1000.0 / real'(CLK_PERIOD_NS));

  // counter widths and compare points
  localparam int DIV_W = 6;
  localparam int CNT_W = 10;
  localparam logic [DIV_W-1:0] TXC_HALF_LAST = DIV_W'(TXC_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CRS_ON_AT = CNT_W'(CRS_ON_CYC - 1);
  localparam logic [CNT_W-1:0] CRS_ON_DONE = CNT_W'(CRS_ON_CYC);
  localparam logic [CNT_W-1:0] CRS_OFF_AT = CNT_W'(CRS_OFF_CYC - 1);
  localparam logic [CNT_W-1:0] SQE_ON_AT = CNT_W'(SQE_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] SQE_OFF_AT = CNT_W'(SQE_DELAY_CYC + SQE_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] LOSS_AT = CNT_W'(LINK_LOSS_CYC - 1);

  // data path
  localparam int TXD_W = 4;
  localparam int FIFO_DEPTH = 16;

  // synchroniser bit layout
  localparam int SEL_W = 2;
  localparam int SY_W = 9;
  localparam int SYI_SEL = 0;
  localparam int SYI_SPD = 2;
  localparam int SYI_LINK = 3;
  localparam int SYI_TXEN = 4;
  localparam int SYI_TXD = 5;

  // led function select codes and levels
  localparam logic [SEL_W-1:0] LED_SEL_SPEED = 2'h0;
  localparam logic [SEL_W-1:0] LED_SEL_LINK = 2'h1;
  localparam logic LED_OFF = 1'h1;

  // reset values
  localparam logic SYNC_RST = 1'h0;
  localparam logic TXC_RST = 1'h0;
  localparam logic LINK_RST = 1'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FRAME = 3'h2,
    ST_TAIL = 3'h4
  } mtx_state_t;

endpackage

// ### src/mtx_sync.sv
/*
  three-stage pin synchroniser; a bit changes only when stages two and three agree.
  assumes inputs asynchronous to clk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module mtx_sync import mtx_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins in, filtered levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;
    // first stage feeds only the second
    always_ff @(posedge clk) begin
      if (!nrst) begin
        s1_ff <= SYNC_RST;
        s2_ff <= SYNC_RST;
        s3_ff <= SYNC_RST;
        q_ff <= SYNC_RST;
      end else begin
        s1_ff <= din[i];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
          q_ff <= s3_ff;
        end
      end
    end
    assign dout[i] = q_ff;
  end

endmodule

// ### src/mtx_top.sv
/*
  10 Mbps mii transmit status: transmit clock, nibble capture, carrier sense,
  sqe heartbeat on collision, link-loss led and interrupt indication.
  assumes the mac launches data on the transmit clock; link_ok comes from the receive side.
*/
`timescale 1ns/1ps
module mtx_top import mtx_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // mii transmit
  output logic mii_tx_clk,
  input wire logic [TXD_W-1:0] mii_txd,
  input wire logic mii_tx_en,
  output logic mii_crs,
  output logic mii_col,
  // link status and strap inputs
  input wire logic link_ok,
  input wire logic speed_100,
  input wire logic [SEL_W-1:0] led_function_select,
  // indication outputs
  output logic led_speed,
  output logic led_link,
  output logic interrupt_out,
  // captured nibble stream
  output logic [TXD_W-1:0] tx_nibble,
  output logic tx_nibble_valid,
  input wire logic tx_nibble_ready,
  output logic tx_overflow
);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [SY_W-1:0] sy_raw;
  logic [SY_W-1:0] sy_q;
  logic [TXD_W-1:0] txd_s;
  logic txen_s;
  logic link_s;
  logic speed_s;
  logic [SEL_W-1:0] sel_s;

  assign sy_raw = {mii_txd, mii_tx_en, link_ok, speed_100, led_function_select};

  mtx_sync #(.W(SY_W)) u_sync (
    .clk(core_clk),
    .nrst(nrst),
    .din(sy_raw),
    .dout(sy_q)
  );

  assign txd_s = sy_q[SYI_TXD +: TXD_W];
  assign txen_s = sy_q[SYI_TXEN];
  assign link_s = sy_q[SYI_LINK];
  assign speed_s = sy_q[SYI_SPD];
  assign sel_s = sy_q[SYI_SEL +: SEL_W];

  ////////////////////////////////////////////////////////////////////////////////
  // transmit clock divider

  logic [DIV_W-1:0] div_cnt_ff;
  logic txc_ff;
  logic half_done;
  logic rise_tick;

  assign half_done = div_cnt_ff == TXC_HALF_LAST;
  assign rise_tick = half_done && !txc_ff;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_cnt_ff <= '0;
      txc_ff <= TXC_RST;
    end else if (half_done) begin
      div_cnt_ff <= '0;
      txc_ff <= ~txc_ff;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  assign mii_tx_clk = txc_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // enable capture at the transmit clock rise

  logic txen_smp_ff;
  logic start_ev;
  logic end_ev;
  logic push_try;
  logic fifo_in_ready;

  // synced pins lag the pin by a few core cycles, well inside the 120 ns setup
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      txen_smp_ff <= 1'h0;
    end else if (rise_tick) begin
      txen_smp_ff <= txen_s;
    end
  end

  assign start_ev = rise_tick && txen_s && !txen_smp_ff;
  assign end_ev = rise_tick && !txen_s && txen_smp_ff;
  assign push_try = rise_tick && txen_s;

  ////////////////////////////////////////////////////////////////////////////////
  // frame state and tail timer

  mtx_state_t st_ff;
  logic [CNT_W-1:0] tail_cnt_ff;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff <= ST_IDLE;
      tail_cnt_ff <= '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (start_ev) begin
            st_ff <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (end_ev) begin
            st_ff <= ST_TAIL;
            tail_cnt_ff <= '0;
          end
        end
        ST_TAIL: begin
          // a new frame in the tail cancels any pending heartbeat
          if (start_ev) begin
            st_ff <= ST_FRAME;
          end else if (tail_cnt_ff == SQE_OFF_AT) begin
            st_ff <= ST_IDLE;
          end else begin
            tail_cnt_ff <= tail_cnt_ff + 1'b1;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // carrier sense

  logic [CNT_W-1:0] crs_on_cnt_ff;
  logic crs_ff;

  // separate on-timer so a frame shorter than the on delay still raises carrier
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      crs_on_cnt_ff <= CRS_ON_DONE;
    end else if (start_ev) begin
      crs_on_cnt_ff <= '0;
    end else if (crs_on_cnt_ff != CRS_ON_DONE) begin
      crs_on_cnt_ff <= crs_on_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      crs_ff <= 1'h0;
    end else if (crs_on_cnt_ff == CRS_ON_AT && !start_ev) begin
      crs_ff <= 1'h1;
    end else if (st_ff == ST_TAIL && tail_cnt_ff == CRS_OFF_AT && !start_ev) begin
      crs_ff <= 1'h0;
    end
  end

  assign mii_crs = crs_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // sqe heartbeat

  logic col_ff;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      col_ff <= 1'h0;
    end else if (start_ev) begin
      col_ff <= 1'h0;
    end else if (st_ff == ST_TAIL && tail_cnt_ff == SQE_ON_AT) begin
      col_ff <= 1'h1;
    end else if (st_ff == ST_TAIL && tail_cnt_ff == SQE_OFF_AT) begin
      col_ff <= 1'h0;
    end
  end

  assign mii_col = col_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // nibble fifo; a full fifo drops the nibble and flags overflow until the next frame

  logic ovf_ff;

  mtx_fifo #(.W(TXD_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .nrst(nrst),
    .in_data(txd_s),
    .in_valid(push_try),
    .in_ready(fifo_in_ready),
    .out_data(tx_nibble),
    .out_valid(tx_nibble_valid),
    .out_ready(tx_nibble_ready)
  );

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ovf_ff <= 1'h0;
    end else if (push_try && !fifo_in_ready) begin
      ovf_ff <= 1'h1;
    end else if (start_ev) begin
      ovf_ff <= 1'h0;
    end
  end

  assign tx_overflow = ovf_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // link-loss reaction, leds and interrupt

  logic [CNT_W-1:0] loss_cnt_ff;
  logic link_ind_ff;
  logic irq_ff;
  logic led_speed_ff;
  logic led_link_ff;
  logic loss_hit;

  function automatic logic led_drive(input logic en, input logic level);
    return en ? level : LED_OFF;
  endfunction

  assign loss_hit = link_ind_ff && !link_s && loss_cnt_ff == LOSS_AT;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      loss_cnt_ff <= '0;
    end else if (link_s || !link_ind_ff) begin
      loss_cnt_ff <= '0;
    end else begin
      loss_cnt_ff <= loss_cnt_ff + 1'b1;
    end
  end

  // restore is indicated at once; only loss waits out the reaction time
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      link_ind_ff <= LINK_RST;
      irq_ff <= 1'h0;
    end else if (link_s) begin
      link_ind_ff <= 1'h1;
      irq_ff <= 1'h0;
    end else if (loss_hit) begin
      link_ind_ff <= 1'h0;
      irq_ff <= 1'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      led_speed_ff <= LED_OFF;
      led_link_ff <= LED_OFF;
    end else begin
      led_speed_ff <= led_drive(sel_s == LED_SEL_SPEED && link_ind_ff, !speed_s);
      led_link_ff <= led_drive(sel_s == LED_SEL_LINK, !link_ind_ff);
    end
  end

  assign led_speed = led_speed_ff;
  assign led_link = led_link_ff;
  assign interrupt_out = irq_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int A_HALF = TXC_HALF_CYC;
  localparam int A_CRS_ON = CRS_ON_CYC;
  localparam int A_SQE_LEN_M1 = SQE_PULSE_CYC - 1;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  clk_high_a: assert property ($rose(txc_ff) |-> ##A_HALF $fell(txc_ff))
    else $error("transmit clock high phase wrong");
  clk_low_a: assert property ($fell(txc_ff) |-> ##A_HALF $rose(txc_ff))
    else $error("transmit clock low phase wrong");
  sample_edge_a: assert property (push_try |=> $rose(txc_ff))
    else $error("nibble captured off the clock rise");
  crs_rise_a: assert property ($rose(txen_smp_ff) |-> ##A_CRS_ON crs_ff)
    else $error("carrier sense late after enable");
  crs_early_a: assert property ($rose(crs_ff) |-> $past(crs_on_cnt_ff) == CRS_ON_AT)
    else $error("carrier sense rose early");
  crs_fall_a: assert property ($fell(crs_ff) |->
    $past(st_ff) == ST_TAIL && $past(tail_cnt_ff) == CRS_OFF_AT)
    else $error("carrier sense dropped at wrong time");
  sqe_delay_a: assert property ($rose(col_ff) |->
    $past(st_ff) == ST_TAIL && $past(tail_cnt_ff) == SQE_ON_AT)
    else $error("sqe raised at wrong delay");
  sqe_width_a: assert property ($rose(col_ff) |->
    ##A_SQE_LEN_M1 (col_ff || st_ff == ST_FRAME) ##1 !col_ff)
    else $error("sqe pulse width wrong");
  speed_led_a: assert property ($fell(link_ind_ff) && sel_s == LED_SEL_SPEED
    |=> led_speed_ff)
    else $error("speed led not high after link loss");
  link_led_a: assert property ($fell(link_ind_ff) && sel_s == LED_SEL_LINK
    |=> led_link_ff)
    else $error("link led not high after link loss");
  loss_irq_a: assert property ($fell(link_ind_ff) |->
    $rose(irq_ff) && $past(loss_cnt_ff) == LOSS_AT)
    else $error("interrupt not tied to link-loss timer");

  frame_c: cover property ($rose(crs_ff));
  sqe_c: cover property ($fell(col_ff) && st_ff == ST_IDLE);
  loss_c: cover property ($rose(irq_ff));
  ovf_c: cover property ($rose(ovf_ff));

endmodule

// ### tb/mtx_mac_model.sv
/*
  mac model on the mii transmit side: sends frames of counted nibbles.
  assumes mii_tx_clk from the block under test and the 200 MHz core clock for launch timing.
*/
`timescale 1ns/1ps
module mtx_mac_model import mtx_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // mii transmit
  input wire logic mii_tx_clk,
  output logic [TXD_W-1:0] mii_txd,
  output logic mii_tx_en
);
  initial begin
    mii_txd = 4'h0;
    mii_tx_en = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // launch one core cycle after the fall, so each nibble stands a half period less one core cycle before the rise
  task automatic next_fall();
    int k;
    logic prev;
    k = 0;
    prev = mii_tx_clk;
    do begin
      prev = mii_tx_clk;
      @(posedge core_clk);
      #1;
      k++;
    end while (!(prev === 1'h1 && mii_tx_clk === 1'h0) && k < 200);
    // a stopped transmit clock counts as a mismatch and ends the run
    if (!(prev === 1'h1 && mii_tx_clk === 1'h0)) begin
      tb_mtx_top.fails++;
      tb_mtx_top.finish_test();
    end
  endtask

  // nibble i carries i; once released the data lines show the inverse of the last nibble
  task automatic send(input int n);
    for (int i = 0; i <= n; i++) begin
      next_fall();
      @(posedge core_clk);
      mii_tx_en <= (i < n);
      mii_txd <= (i < n) ? TXD_W'(i) : ~mii_txd;
    end
  endtask
endmodule

// ### tb/tb_mtx_top.sv
/*
  self-checking bench for the mii transmit status block with a mac model.
  assumes the package timing figures and the hand-over latencies of the block.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_mtx_top import mtx_pkg::*;;
  logic core_clk, nrst, mii_tx_clk, mii_tx_en, mii_crs, mii_col, link_ok, speed_100;
  logic led_speed, led_link, interrupt_out, tx_nibble_valid, tx_nibble_ready, tx_overflow;
  logic [TXD_W-1:0] mii_txd, tx_nibble;
  logic [SEL_W-1:0] led_function_select;
  logic [TXD_W-1:0] got[$];
  int fails, checks;

  mtx_top mtx_top_i (.core_clk(core_clk), .nrst(nrst), .mii_tx_clk(mii_tx_clk),
    .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .mii_crs(mii_crs), .mii_col(mii_col),
    .link_ok(link_ok), .speed_100(speed_100), .led_function_select(led_function_select),
    .led_speed(led_speed), .led_link(led_link), .interrupt_out(interrupt_out),
    .tx_nibble(tx_nibble), .tx_nibble_valid(tx_nibble_valid),
    .tx_nibble_ready(tx_nibble_ready), .tx_overflow(tx_overflow));
  mtx_mac_model mtx_mac_model_i (.core_clk(core_clk), .nrst(nrst), .mii_tx_clk(mii_tx_clk),
    .mii_txd(mii_txd), .mii_tx_en(mii_tx_en));

  always #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;
  // collector acts like a flop, so it sees the pre-edge values
  always @(posedge core_clk) begin
    if (nrst && tx_nibble_valid && tx_nibble_ready) begin
      got.push_back(tx_nibble);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return mii_tx_clk;
      1: return mii_crs;
      2: return mii_col;
      3: return interrupt_out;
      4: return mii_tx_en;
      5: return led_speed;
      default: return led_link;
    endcase
  endfunction

  // counts cycles, sampled 1 ns after each edge, until the chosen signal reaches lvl
  task automatic wait_for(input int s, input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pick(s) !== lvl && n < lim);
    if (pick(s) !== lvl) begin
      fails++;
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic clock_check();
    int n;
    wait_for(0, 1'h1, 100, n);
    wait_for(0, 1'h0, 100, n);
    `CHK(n, TXC_HALF_CYC)
    wait_for(0, 1'h1, 100, n);
    `CHK(n, TXC_HALF_CYC)
  endtask

  task automatic frame_check();
    int n, m;
    got.delete();
    fork
      mtx_mac_model_i.send(6);
      begin
        wait_for(4, 1'h1, 200, m);
        wait_for(0, 1'h1, 200, m);
        wait_for(1, 1'h1, 300, m);
        `CHK(m, CRS_ON_CYC)
      end
    join
    // first rise that captures the low enable
    wait_for(0, 1'h1, 200, n);
    wait_for(1, 1'h0, 400, n);
    `CHK(n, CRS_OFF_CYC)
    wait_for(2, 1'h1, 400, n);
    `CHK(n, SQE_DELAY_CYC - CRS_OFF_CYC)
    wait_for(2, 1'h0, 400, n);
    `CHK(n, SQE_PULSE_CYC)
    `CHK(got.size(), 6)
    for (int i = 0; i < 6 && i < got.size(); i++) `CHK(got[i], TXD_W'(i))
  endtask

  // consumer stalls through a 20-nibble frame; the 17 words held must come out in order
  task automatic fill_check();
    int n;
    @(posedge core_clk);
    tx_nibble_ready <= 1'h0;
    got.delete();
    mtx_mac_model_i.send(20);
    wait_for(0, 1'h1, 200, n);
    `CHK(tx_overflow, 1'h1)
    @(posedge core_clk);
    tx_nibble_ready <= 1'h1;
    for (int k = 0; k < 100; k++) begin
      @(posedge core_clk);
      #1;
      if (tx_nibble_valid === 1'h0) break;
    end
    `CHK(tx_nibble_valid, 1'h0)
    if (tx_nibble_valid !== 1'h0) finish_test();
    `CHK(got.size(), 17)
    for (int i = 0; i < 17 && i < got.size(); i++) `CHK(got[i], TXD_W'(i))
  endtask

  // a short loss is ignored, a held loss raises the interrupt and then the mode's led
  task automatic link_check(input logic [SEL_W-1:0] mode);
    int n, s;
    s = (mode == LED_SEL_SPEED) ? 5 : 6;
    @(posedge core_clk);
    led_function_select <= mode;
    link_ok <= 1'h1;
    wait_for(s, 1'h0, 50, n);
    @(posedge core_clk);
    link_ok <= 1'h0;
    repeat (400) @(posedge core_clk);
    link_ok <= 1'h1;
    #1;
    `CHK(interrupt_out, 1'h0)
    repeat (20) @(posedge core_clk);
    link_ok <= 1'h0;
    wait_for(3, 1'h1, 1000, n);
    `CHK(n >= LINK_LOSS_CYC && n <= LINK_LOSS_CYC + 8, 1'h1)
    `CHK(pick(s), 1'h0)
    @(posedge core_clk);
    #1;
    `CHK(pick(s), 1'h1)
    @(posedge core_clk);
    link_ok <= 1'h1;
    wait_for(3, 1'h0, 20, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    nrst = 1'h0;
    link_ok = 1'h1;
    speed_100 = 1'h1;
    led_function_select = LED_SEL_SPEED;
    tx_nibble_ready = 1'h1;
    fails = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'h1;
    clock_check();
    frame_check();
    fill_check();
    link_check(LED_SEL_SPEED);
    link_check(LED_SEL_LINK);
    finish_test();
  end
endmodule
